// >>> core/tmr_ctrl.sv
// tmr_ctrl: 8-bit timer control, mode decode, compare outputs, registers
// assumes: avalon-mm master, timer tick as a one-cycle enable, synchronous inputs
//
// Behaviour
// - counter moves only on clock cycles where the timer tick is high or the count register is written
// - nonzero channel a output mode takes the pin; driven only if direction is output
// - normal/clear-on-match: a modes off, toggle, clear, set on match
// - fast mode a: 01 toggles only with upper mode bit; 10/11 match then bottom
// - fast mode a: compare equal top with high bit, act only at bottom
// - phase mode a: 01 toggles only with upper bit; 10/11 up and down matches
// - phase mode a: compare equal top with high bit, act only at top
// - nonzero channel b output mode takes the pin; driven only if direction is output
// - normal/clear-on-match: b modes off, toggle, clear, set on match
// - fast mode b: 01 reserved; 10/11 act on match then at bottom
// - fast mode b: compare equal top with high bit, act only at bottom
// - phase mode b: 01 reserved; 10/11 act on up and down matches
// - phase mode b: compare equal top with high bit, act only at top
// - control a bits 3 and 2 ignore writes and read zero
// - mode field decodes 0,1,2,3,5,7; 4 and 6 reserved
// - top is 0xff in modes 0,1,3, compare a in modes 2,5,7
// - overflow flag at max in 0,2,3, bottom in 1,5, top in 7
// - match flags set on compare match
// - clear-on-match and fast with a as top: a match sets flag, clears counter
// - two pin-select registers, eight two-bit fields, reset zero
// - upper mode bit is bit 3 of control b, joined with two low bits
`timescale 1ns/10ps
module tmr_ctrl
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic timer_tick_i,
  input wire logic dir_a_out_i,
  input wire logic dir_b_out_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic override_a_o,
  output logic override_b_o,
  output logic drive_a_o,
  output logic drive_b_o,
  output logic [2:0] flags_o,
  output logic [7:0] count_value_o,
  output logic [15:0] pin_select_field_o
);

  typedef struct packed {
    logic wait_n;
    logic [7:0] rdata;
    logic [1:0] chan_a_out_mode;
    logic [1:0] chan_b_out_mode;
    logic [1:0] wave_lo;
    logic wave_mode_upper_bit;
    logic [15:0] psel;
    logic [7:0] count_value;
    logic down;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] flags;
    logic wave_out_a;
    logic wave_out_b;
    logic override_a;
    logic override_b;
    logic drive_a;
    logic drive_b;
  } tmr_state_s;

  tmr_state_s st;
  tmr_state_s next_st;

  // mode field to counting kind
  function automatic tmr_pkg::tmr_kind_e kind_of(input logic [2:0] m);
    case (m)
      3'd1, 3'd5: kind_of = tmr_pkg::K_PHASE;
      3'd3, 3'd7: kind_of = tmr_pkg::K_FAST;
      default: kind_of = tmr_pkg::K_NORM;
    endcase
  endfunction

  // output mode nonzero: waveform takes the pin
  function automatic logic pin_taken(input logic [1:0] om);
    pin_taken = (om != tmr_pkg::OM_OFF);
  endfunction

  // one counter step in the given direction
  function automatic logic [7:0] cnt_step(input logic [7:0] v, input logic dn);
    if (dn)
      cnt_step = v - 8'h01;
    else
      cnt_step = v + 8'h01;
  endfunction

  // modes whose top comes from compare a
  function automatic logic top_from_a(input logic [2:0] m);
    case (m)
      3'd2, 3'd5, 3'd7: top_from_a = 1'b1;
      default: top_from_a = 1'b0;
    endcase
  endfunction

  // point at which the overflow flag is raised
  function automatic logic ovf_at(
    input logic [2:0] m,
    input logic dn,
    input logic bottom,
    input logic top_hit,
    input logic max_hit
  );
    case (m)
      3'd1, 3'd5: ovf_at = dn && bottom;
      3'd7: ovf_at = top_hit;
      3'd0, 3'd2, 3'd3: ovf_at = max_hit;
      default: ovf_at = 1'b0;
    endcase
  endfunction

  // next waveform level for one channel on a tick
  function automatic logic wave_next(
    input logic cur,
    input logic [1:0] om,
    input tmr_pkg::tmr_kind_e k,
    input logic tog_ok,
    input logic match,
    input logic down,
    input logic at_top,
    input logic at_wrap,
    input logic cmp_top
  );
    logic r;
    r = cur;
    case (k)
      tmr_pkg::K_NORM:
      begin
        if (match)
        begin
          case (om)
            tmr_pkg::OM_TOGGLE: r = ~cur;
            tmr_pkg::OM_CLEAR: r = 1'b0;
            tmr_pkg::OM_SET: r = 1'b1;
            default: r = cur;
          endcase
        end
      end
      tmr_pkg::K_FAST:
      begin
        if (om == tmr_pkg::OM_TOGGLE)
        begin
          if (tog_ok && match)
            r = ~cur;
        end
        else if (om[1])
        begin
          if (at_wrap)
            r = ~om[0];
          else if (match && !cmp_top)
            r = om[0];
        end
      end
      tmr_pkg::K_PHASE:
      begin
        if (om == tmr_pkg::OM_TOGGLE)
        begin
          if (tog_ok && match)
            r = ~cur;
        end
        else if (om[1])
        begin
          if (cmp_top)
          begin
            if (at_top)
              r = ~om[0];
          end
          else if (match)
            r = down ? ~om[0] : om[0];
        end
      end
      default: r = cur;
    endcase
    wave_next = r;
  endfunction

  logic [2:0] mode;
  tmr_pkg::tmr_kind_e kind;
  logic top_is_a;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic wrap;
  logic ovf;
  logic acc_ok;
  logic [7:0] idx;
  logic [7:0] rd_val;
  logic wr_en;
  logic [2:0] w1c;

  always_comb
  begin
    mode = {st.wave_mode_upper_bit, st.wave_lo};
    kind = kind_of(mode);
    top_is_a = top_from_a(mode);
    top = top_is_a ? st.compare_value_a : tmr_pkg::CNT_MAX;
    at_top = (st.count_value == top);
    at_bottom = (st.count_value == tmr_pkg::CNT_BOTTOM);
    match_a = timer_tick_i && (st.count_value == st.compare_value_a);
    match_b = timer_tick_i && (st.count_value == st.compare_value_b);
    wrap = timer_tick_i && (kind == tmr_pkg::K_FAST) && at_top;
    ovf = timer_tick_i && ovf_at(mode, st.down, at_bottom, at_top,
      st.count_value == tmr_pkg::CNT_MAX);
    idx = avs_address_i[9:2];
    acc_ok = !st.wait_n && (avs_address_i[1:0] == 2'h0);
    wr_en = acc_ok && avs_write_i && avs_byteenable_i[0];
    case (idx)
      tmr_pkg::IDX_CTRL_A:
        rd_val = {st.chan_a_out_mode, st.chan_b_out_mode, 2'h0, st.wave_lo};
      tmr_pkg::IDX_CTRL_B:
        rd_val = {4'h0, st.wave_mode_upper_bit, 3'h0};
      tmr_pkg::IDX_COUNT: rd_val = st.count_value;
      tmr_pkg::IDX_FLAGS: rd_val = {5'h00, st.flags};
      tmr_pkg::IDX_CMP_A: rd_val = st.buf_a;
      tmr_pkg::IDX_CMP_B: rd_val = st.buf_b;
      tmr_pkg::IDX_PSEL_LO: rd_val = st.psel[7:0];
      tmr_pkg::IDX_PSEL_HI: rd_val = st.psel[15:8];
      default: rd_val = tmr_pkg::RST_REG8;
    endcase
    w1c = (wr_en && idx == tmr_pkg::IDX_FLAGS) ? avs_writedata_i[2:0] : 3'h0;

    next_st = st;
    // bus handshake: one wait cycle, then the answer
    if ((avs_read_i || avs_write_i) && st.wait_n)
    begin
      next_st.wait_n = 1'b0;
      next_st.rdata = rd_val;
    end
    else
      next_st.wait_n = 1'b1;

    // counter
    if (timer_tick_i)
    begin
      case (kind)
        tmr_pkg::K_PHASE:
        begin
          if (!st.down && at_top)
          begin
            next_st.down = 1'b1;
            next_st.count_value = cnt_step(st.count_value, 1'b1);
          end
          else if (st.down && at_bottom)
          begin
            next_st.down = 1'b0;
            next_st.count_value = cnt_step(st.count_value, 1'b0);
          end
          else
            next_st.count_value = cnt_step(st.count_value, st.down);
        end
        tmr_pkg::K_FAST:
        begin
          next_st.down = 1'b0;
          next_st.count_value = at_top ? tmr_pkg::CNT_BOTTOM : cnt_step(st.count_value, 1'b0);
        end
        default:
        begin
          next_st.down = 1'b0;
          if (mode == 3'd2 && match_a)
            next_st.count_value = tmr_pkg::CNT_BOTTOM;
          else
            next_st.count_value = cnt_step(st.count_value, 1'b0);
        end
      endcase
    end

    // compare update points
    case (kind)
      tmr_pkg::K_PHASE:
      begin
        if (timer_tick_i && !st.down && at_top)
        begin
          next_st.compare_value_a = st.buf_a;
          next_st.compare_value_b = st.buf_b;
        end
      end
      tmr_pkg::K_FAST:
      begin
        if (wrap)
        begin
          next_st.compare_value_a = st.buf_a;
          next_st.compare_value_b = st.buf_b;
        end
      end
      default:
      begin
        next_st.compare_value_a = st.buf_a;
        next_st.compare_value_b = st.buf_b;
      end
    endcase

    // waveforms
    next_st.wave_out_a = wave_next(st.wave_out_a, st.chan_a_out_mode, kind,
      st.wave_mode_upper_bit, match_a, st.down, timer_tick_i && at_top, wrap,
      st.compare_value_a == top);
    next_st.wave_out_b = wave_next(st.wave_out_b, st.chan_b_out_mode, kind,
      1'b0, match_b, st.down, timer_tick_i && at_top, wrap,
      st.compare_value_b == top);
    next_st.override_a = pin_taken(st.chan_a_out_mode);
    next_st.override_b = pin_taken(st.chan_b_out_mode);
    next_st.drive_a = pin_taken(st.chan_a_out_mode) && dir_a_out_i;
    next_st.drive_b = pin_taken(st.chan_b_out_mode) && dir_b_out_i;

    // flags: write one clears, a new event wins
    next_st.flags = st.flags & ~w1c;
    if (ovf)
      next_st.flags[tmr_pkg::FL_OVF] = 1'b1;
    if (match_a)
      next_st.flags[tmr_pkg::FL_MATCH_A] = 1'b1;
    if (match_b)
      next_st.flags[tmr_pkg::FL_MATCH_B] = 1'b1;

    // register writes
    if (wr_en)
    begin
      case (idx)
        tmr_pkg::IDX_CTRL_A:
        begin
          next_st.chan_a_out_mode = avs_writedata_i[tmr_pkg::CA_MODE_A_POS +: 2];
          next_st.chan_b_out_mode = avs_writedata_i[tmr_pkg::CA_MODE_B_POS +: 2];
          next_st.wave_lo = avs_writedata_i[tmr_pkg::CA_WAVE_POS +: 2];
        end
        tmr_pkg::IDX_CTRL_B:
          next_st.wave_mode_upper_bit = avs_writedata_i[tmr_pkg::CB_UPPER_POS];
        tmr_pkg::IDX_COUNT:
        begin
          next_st.count_value = avs_writedata_i[7:0];
          next_st.down = 1'b0;
        end
        tmr_pkg::IDX_CMP_A: next_st.buf_a = avs_writedata_i[7:0];
        tmr_pkg::IDX_CMP_B: next_st.buf_b = avs_writedata_i[7:0];
        tmr_pkg::IDX_PSEL_LO: next_st.psel[7:0] = avs_writedata_i[7:0];
        tmr_pkg::IDX_PSEL_HI: next_st.psel[15:8] = avs_writedata_i[7:0];
        default: next_st.flags = next_st.flags;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st <= '0;
      st.wait_n <= 1'b1;
      st.psel <= tmr_pkg::RST_PSEL;
    end
    else
      st <= next_st;
  end

  assign avs_readdata_o = {24'h000000, st.rdata};
  assign avs_waitrequest_o = st.wait_n;
  assign wave_out_a_o = st.wave_out_a;
  assign wave_out_b_o = st.wave_out_b;
  assign override_a_o = st.override_a;
  assign override_b_o = st.override_b;
  assign drive_a_o = st.drive_a;
  assign drive_b_o = st.drive_b;
  assign flags_o = st.flags;
  assign count_value_o = st.count_value;
  assign pin_select_field_o = st.psel;

endmodule // tmr_ctrl

// >>> core/tmr_pkg.sv
// tmr_pkg: register indices, field positions, reset values and mode codes
// assumes: one 100 MHz clock, registers reached over avalon-mm
package tmr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'h50;
  localparam logic [7:0] IDX_CTRL_B = 8'h53;
  localparam logic [7:0] IDX_COUNT = 8'h52;
  localparam logic [7:0] IDX_FLAGS = 8'h55;
  localparam logic [7:0] IDX_CMP_A = 8'h56;
  localparam logic [7:0] IDX_CMP_B = 8'h5c;
  localparam logic [7:0] IDX_PSEL_LO = 8'h67;
  localparam logic [7:0] IDX_PSEL_HI = 8'h68;
  // control a fields
  localparam int CA_MODE_A_POS = 6;
  localparam int CA_MODE_B_POS = 4;
  localparam int CA_WAVE_POS = 0;
  // control b field
  localparam int CB_UPPER_POS = 3;
  // flag positions
  localparam int FL_OVF = 0;
  localparam int FL_MATCH_A = 1;
  localparam int FL_MATCH_B = 2;
  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_PSEL = 16'h0000;
  // fixed counter values
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // counting kinds
  typedef enum logic [2:0]
  {
    K_NORM = 3'b001,
    K_PHASE = 3'b010,
    K_FAST = 3'b100
  } tmr_kind_e;
  // output-mode encodings
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
endpackage

// >>> verif/test_tmr_ctrl.sv
// test_tmr_ctrl: self-checking bench for the timer control block
// assumes: tmr_ctrl and its package compiled first, checker bound to it
`timescale 1ns/10ps
module test_tmr_ctrl;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic timer_tick_i = 1'b0;
  logic dir_a_out_i = 1'b1;
  logic dir_b_out_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, wave_out_a_o, wave_out_b_o, override_a_o, override_b_o, pa;
  logic drive_a_o, drive_b_o;
  logic [2:0] flags_o;
  logic [7:0] count_value_o, rd, c, lo, hi;
  logic [15:0] pin_select_field_o;
  logic [31:0] seed = 32'h70dc;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  tmr_ctrl u_tmr_ctrl
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .timer_tick_i(timer_tick_i),
    .dir_a_out_i(dir_a_out_i),
    .dir_b_out_i(dir_b_out_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o),
    .override_a_o(override_a_o),
    .override_b_o(override_b_o),
    .drive_a_o(drive_a_o),
    .drive_b_o(drive_b_o),
    .flags_o(flags_o),
    .count_value_o(count_value_o),
    .pin_select_field_o(pin_select_field_o)
  );
  initial forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'hf3;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(rd, e);
  endtask
  task automatic ticks(input int n);
    timer_tick_i <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    timer_tick_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  // modes off, compare values loaded, counter and flags cleared
  task automatic arm(input logic [7:0] ub, input logic [7:0] ca, input logic [7:0] cb);
    wr(tmr_pkg::IDX_CTRL_A, 8'h00);
    wr(tmr_pkg::IDX_CTRL_B, ub);
    wr(tmr_pkg::IDX_CMP_A, ca);
    wr(tmr_pkg::IDX_CMP_B, cb);
    wr(tmr_pkg::IDX_COUNT, 8'h00);
    wr(tmr_pkg::IDX_FLAGS, 8'h07);
  endtask
  task automatic done(input string nm);
    $display("test %0s finished", nm);
  endtask
  // a clears and b sets on the rising match; opposite at bottom or down match
  task automatic pwm(input logic [7:0] ctl, input logic ph, input string nm);
    int tot;
    c = 8'h01 + (rnd() % 8'hfd);
    tot = ph ? 511 - c : 256;
    wr(tmr_pkg::IDX_CTRL_A, 8'h00);
    wr(tmr_pkg::IDX_CMP_A, c);
    wr(tmr_pkg::IDX_CMP_B, c);
    wr(tmr_pkg::IDX_COUNT, 8'h00);
    wr(tmr_pkg::IDX_CTRL_A, ctl);
    ticks(c + 1);
    check(count_value_o, c + 8'h01);
    check({wave_out_a_o, wave_out_b_o}, 2'b01);
    ticks(tot - c - 1);
    check({wave_out_a_o, wave_out_b_o}, 2'b10);
    done(nm);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(negedge core_clk_i);
    check(pin_select_field_o, 16'h0000);
    rchk(tmr_pkg::IDX_CTRL_A, 8'h00);
    rchk(tmr_pkg::IDX_PSEL_LO, 8'h00);
    rchk(tmr_pkg::IDX_PSEL_HI, 8'h00);
    done("reset");
    c = rnd();
    wr(tmr_pkg::IDX_CMP_A, c);
    wr(tmr_pkg::IDX_CMP_B, ~c);
    wr(tmr_pkg::IDX_COUNT, 8'h00);
    wr(tmr_pkg::IDX_CTRL_A, 8'h50);
    ticks(256);
    check({wave_out_a_o, wave_out_b_o}, 2'b11);
    check(flags_o, 3'b111);
    check(count_value_o, 8'h00);
    wr(tmr_pkg::IDX_FLAGS, 8'h07);
    rchk(tmr_pkg::IDX_FLAGS, 8'h00);
    done("normal");
    pwm(8'hb3, 1'b0, "fast");
    pwm(8'hb1, 1'b1, "phase");
    wr(tmr_pkg::IDX_CTRL_A, 8'hff);
    rchk(tmr_pkg::IDX_CTRL_A, ctrl_exp(8'hff));
    dir_a_out_i <= seed[0];
    dir_b_out_i <= seed[1];
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check({override_a_o, override_b_o}, 2'b11);
    check({drive_a_o, drive_b_o}, {dir_a_out_i, dir_b_out_i});
    wr(tmr_pkg::IDX_CTRL_B, 8'hff);
    rchk(tmr_pkg::IDX_CTRL_B, 8'h08);
    rchk(8'h7f, 8'h00);
    done("control");
    lo = rnd();
    hi = rnd();
    wr(tmr_pkg::IDX_PSEL_LO, lo);
    wr(tmr_pkg::IDX_PSEL_HI, hi);
    rchk(tmr_pkg::IDX_PSEL_LO, lo);
    rchk(tmr_pkg::IDX_PSEL_HI, hi);
    @(negedge core_clk_i);
    check(pin_select_field_o, {hi, lo});
    done("pin select");
    c = 8'h02 + (rnd() % 8'hf0);
    arm(8'h00, c, 8'hff);
    wr(tmr_pkg::IDX_CTRL_A, 8'h42);
    pa = wave_out_a_o;
    ticks(c + 1);
    check(count_value_o, 8'h00);
    check(wave_out_a_o, {~pa});
    check(flags_o, 3'b010);
    ticks(c + 1);
    check({count_value_o, wave_out_a_o}, {8'h00, pa});
    done("clear on match");
    c = 8'h02 + (rnd() % 8'hf0);
    arm(8'h08, c, c);
    wr(tmr_pkg::IDX_CTRL_A, 8'h63);
    pa = wave_out_a_o;
    ticks(c + 1);
    check(count_value_o, 8'h00);
    check(flags_o, 3'b111);
    check({wave_out_a_o, wave_out_b_o}, {~pa, 1'b1});
    done("fast top a");
    c = 8'h02 + (rnd() % 8'hf0);
    arm(8'h08, c, c);
    wr(tmr_pkg::IDX_CTRL_A, 8'h61);
    pa = wave_out_a_o;
    ticks(c + 1);
    check(count_value_o, c - 8'h01);
    check(flags_o, 3'b110);
    check({wave_out_a_o, wave_out_b_o}, {~pa, 1'b1});
    ticks(c);
    check(count_value_o, 8'h01);
    check(flags_o, 3'b111);
    done("phase top a");
    conclude();
  end
endmodule // test_tmr_ctrl

// >>> verif/tmr_ctrl_asserts.sv
// tmr_ctrl_asserts: port-level checks of the timer control block
// assumes: bound to tmr_ctrl, one clock, synchronous active-low reset
`timescale 1ns/10ps
module tmr_ctrl_asserts
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic timer_tick_i,
  input wire logic dir_a_out_i,
  input wire logic dir_b_out_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic drive_a_o,
  input wire logic drive_b_o,
  input wire logic [2:0] flags_o,
  input wire logic [7:0] count_value_o,
  input wire logic [15:0] pin_select_field_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_answer_one_cycle:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer off");
  a_read_upper_zero:
    assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
  a_count_holds:
    assert property (!timer_tick_i && !(avs_write_i && !avs_waitrequest_o)
      |=> $stable(count_value_o)) else $error("count moved without tick");
  a_drive_a_dir:
    assert property (!dir_a_out_i |=> !drive_a_o) else $error("pin a driven as input");
  a_drive_b_dir:
    assert property (!dir_b_out_i |=> !drive_b_o) else $error("pin b driven as input");
  a_ctrl_resv_zero:
    assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == {tmr_pkg::IDX_CTRL_A, 2'b00} |-> avs_readdata_o[3:2] == 2'b00)
      else $error("reserved control bits read nonzero");
  a_psel_reset_zero:
    assert property ($rose(nrst_i) |-> pin_select_field_o == 16'h0000)
      else $error("pin select not zero after reset");
  a_match_b_sticky:
    assert property (flags_o[2] && !avs_write_i |=> flags_o[2]) else $error("flag b lost");
  a_ovf_needs_tick:
    assert property (!flags_o[0] && !timer_tick_i |=> !flags_o[0])
      else $error("overflow flag set without tick");
  a_match_b_tick:
    assert property (!flags_o[2] && !timer_tick_i |=> !flags_o[2])
      else $error("match flag b set without tick");
  a_psel_holds:
    assert property (!(avs_write_i && !avs_waitrequest_o) |=> $stable(pin_select_field_o))
      else $error("pin select changed without write");
  a_ctrl_b_resv:
    assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == {tmr_pkg::IDX_CTRL_B, 2'b00}
      |-> (avs_readdata_o[7:0] & 8'hf7) == 8'h00)
      else $error("control b unused bits read nonzero");
endmodule // tmr_ctrl_asserts
bind tmr_ctrl tmr_ctrl_asserts u_tmr_ctrl_asserts
(
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .timer_tick_i(timer_tick_i),
  .dir_a_out_i(dir_a_out_i),
  .dir_b_out_i(dir_b_out_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .drive_a_o(drive_a_o),
  .drive_b_o(drive_b_o),
  .flags_o(flags_o),
  .count_value_o(count_value_o),
  .pin_select_field_o(pin_select_field_o)
);
